// File: inc/led_serial_pkg.sv
// shared widths, carrier types and states of the led serial input block
`default_nettype none

package led_serial_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int CHANNELS  = 16;
  localparam int GS_BITS   = 192;
  localparam int DC_BITS   = 96;
  localparam int HALF_BITS = 96;
  localparam int ST_BITS   = 17;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic latch_strobe;
    logic blank;
    logic mode;
    logic ext_iface_select_n;
  } pins_t;

  // overtemp_flag sits above the sixteen open_led_flags
  typedef struct packed {
    logic                overtemp_flag;
    logic [CHANNELS-1:0] open_led_flags;
  } status_bits_t;

  typedef struct packed {
    logic dc_mode;
    logic ext;
    logic half_hi;
  } link_ctrl_t;

  // ------------------------------------------------------------------
  // half-register selection
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HALF_NONE,
    HALF_LOW,
    HALF_HIGH
  } half_t;

endpackage : led_serial_pkg

`default_nettype wire

// File: rtl/bit_sync.sv
// two-flop level synchroniser, parameterised width
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : bit_sync

`default_nettype wire

// File: rtl/link_shifter.sv
// serial shift register running on the serial shift clock
`default_nettype none

module link_shifter
  import led_serial_pkg::*;
(
  // link clock and system reset (synchronised here)
  input  wire logic               i_serial_clk,
  input  wire logic               i_sys_rst,
  // serial data
  input  wire logic               i_serial_in,
  output logic                    o_serial_out,
  // steering from the system domain
  input  wire link_ctrl_t         i_ctrl,
  input  wire logic               i_load_tgl,
  input  wire status_bits_t       i_status,
  // register contents, quasi-static while the clock rests
  output logic      [GS_BITS-1:0] o_shreg
);

  logic               link_rst;
  link_ctrl_t         ctrl;
  logic               load_tgl;
  logic               load_seen;
  logic               out_fall;
  logic [GS_BITS-1:0] next_shreg;

  // ------------------------------------------------------------------
  // crossings into the link domain
  // ------------------------------------------------------------------
  bit_sync #(.W(1)) u_rst_sync (
    .i_clock   (i_serial_clk),
    .i_sys_rst (1'b0),
    .i_async   (i_sys_rst),
    .o_sync    (link_rst)
  );

  bit_sync #(.W($bits(link_ctrl_t) + 1)) u_ctrl_sync (
    .i_clock   (i_serial_clk),
    .i_sys_rst (link_rst),
    .i_async   ({i_ctrl, i_load_tgl}),
    .o_sync    ({ctrl, load_tgl})
  );

  // ------------------------------------------------------------------
  // shift path selection
  // ------------------------------------------------------------------
  wire short_path = ctrl.dc_mode | ctrl.ext;
  wire load_req   = (load_tgl != load_seen) & ~ctrl.dc_mode;
  wire [GS_BITS-1:0] shift_full = {o_shreg[GS_BITS-2:0], i_serial_in};
  wire [GS_BITS-1:0] shift_half =
    {o_shreg[GS_BITS-1:DC_BITS], o_shreg[DC_BITS-2:0], i_serial_in};

  always_comb begin
    next_shreg = short_path ? shift_half : shift_full;
    if (load_req && !ctrl.ext) begin
      next_shreg[GS_BITS-1 -: ST_BITS] = i_status;
    end else if (load_req && ctrl.half_hi) begin
      next_shreg[DC_BITS-1 -: ST_BITS] = i_status;
    end
  end

  always_ff @(posedge i_serial_clk) begin
    if (link_rst) begin
      o_shreg   <= '0;
      load_seen <= 1'b0;
    end else begin
      o_shreg   <= next_shreg;
      load_seen <= load_tgl;
    end
  end

  // retimed copy for long links
  always_ff @(negedge i_serial_clk) begin
    if (link_rst) begin
      out_fall <= 1'b0;
    end else begin
      out_fall <= o_shreg[DC_BITS-1];
    end
  end

  // chain output: msb of the active path, no cascade depth limit
  assign o_serial_out = ctrl.ext ? out_fall :
    (short_path ? o_shreg[DC_BITS-1] : o_shreg[GS_BITS-1]);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_shift_sample;
    @(posedge i_serial_clk) disable iff (link_rst)
      1'b1 |=> o_shreg[0] == $past(i_serial_in);
  endproperty
  a_shift_sample: assert property (p_shift_sample)
    else $error("serial input not sampled on rising edge");

  property p_low_half_no_status;
    @(posedge i_serial_clk) disable iff (link_rst)
      load_req && ctrl.ext && !ctrl.half_hi
        |=> o_shreg[DC_BITS-1 -: ST_BITS] == $past(o_shreg[DC_BITS-2 -: ST_BITS]);
  endproperty
  a_low_half_no_status: assert property (p_low_half_no_status)
    else $error("status loaded while lower half selected");

  property p_status_load;
    @(posedge i_serial_clk) disable iff (link_rst)
      load_req && !ctrl.ext |=> o_shreg[GS_BITS-1 -: ST_BITS] == $past(i_status);
  endproperty
  a_status_load: assert property (p_status_load)
    else $error("status bits not loaded into upper shift bits");

endmodule : link_shifter

`default_nettype wire

// File: rtl/led_serial_input.sv
// serial input, latch and half-select logic of a sixteen channel led sink driver
`default_nettype none

// Operation
// - mode low 192-bit grayscale, high 96-bit trim
// - chain imposes no fixed cascade length limit
// - select input low enables extended interface
// - blanked latch pulses: one low, two high half
// - extended mode retimes serial out to falling edge
// - serial input sampled on rising clock edge
// - status shifted out only for upper half
// - extended applies only to grayscale, trim unchanged
// - latch fall loads seventeen status bits on top
// - normal mode serial out moves on rising edge
// - serial out feeds next device serial in
// - blank high turns sinks off, clears counter
module led_serial_input
  import led_serial_pkg::*;
(
  // system clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_sys_rst,
  // serial link
  input  wire logic                i_serial_clk,
  input  wire logic                i_serial_in,
  output logic                     o_serial_out,
  // control pins
  input  wire logic                i_latch_strobe,
  input  wire logic                i_blank,
  input  wire logic                i_mode,
  input  wire logic                i_ext_iface_select_n,
  // error sources
  input  wire logic [CHANNELS-1:0] i_open_led_flags,
  input  wire logic                i_overtemp_flag,
  // latched data
  output logic      [GS_BITS-1:0]  o_pwm_level_data,
  output logic      [DC_BITS-1:0]  o_current_trim_data,
  // output control and selection state
  output logic                     o_sinks_off,
  output logic                     o_count_clear,
  output logic                     o_lower_half_sel,
  output logic                     o_upper_half_sel
);

  pins_t              pin_raw;
  pins_t              pin;
  status_bits_t       flag_raw;
  status_bits_t       flags;
  status_bits_t       status_hold;
  link_ctrl_t         ctrl;
  half_t              half;
  half_t              next_half;
  logic               latch_prev;
  logic               blank_prev;
  logic               load_tgl;
  logic [GS_BITS-1:0] link_shreg;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  assign pin_raw = '{latch_strobe       : i_latch_strobe,
                     blank              : i_blank,
                     mode               : i_mode,
                     ext_iface_select_n : i_ext_iface_select_n};

  assign flag_raw = '{overtemp_flag  : i_overtemp_flag,
                      open_led_flags : i_open_led_flags};

  // pin sync runs through reset, so the edge registers start from the real
  // pin levels and no false blank edge follows reset
  bit_sync #(.W($bits(pins_t))) u_pin_sync (
    .i_clock   (i_clock),
    .i_sys_rst (1'b0),
    .i_async   (pin_raw),
    .o_sync    (pin)
  );

  bit_sync #(.W($bits(status_bits_t))) u_flag_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   (flag_raw),
    .o_sync    (flags)
  );

  // ------------------------------------------------------------------
  // link-side shift register
  // ------------------------------------------------------------------
  link_shifter u_link (
    .i_serial_clk (i_serial_clk),
    .i_sys_rst    (i_sys_rst),
    .i_serial_in  (i_serial_in),
    .o_serial_out (o_serial_out),
    .i_ctrl       (ctrl),
    .i_load_tgl   (load_tgl),
    .i_status     (status_hold),
    .o_shreg      (link_shreg)
  );

  // ------------------------------------------------------------------
  // edge and mode decode
  // ------------------------------------------------------------------
  wire latch_rise = pin.latch_strobe & ~latch_prev;
  wire latch_fall = ~pin.latch_strobe & latch_prev;
  wire blank_rise = pin.blank & ~blank_prev;
  wire ext_gs     = ~pin.ext_iface_select_n & ~pin.mode;

  wire count_pulse = latch_rise & pin.blank & ext_gs;
  wire load_full   = latch_rise & ~pin.mode & ~ext_gs;
  wire load_trim   = latch_rise & pin.mode;
  wire load_half   = latch_rise & ~pin.blank & ext_gs;
  wire arm_status  = latch_fall & ~pin.mode;

  wire [HALF_BITS-1:0] half_word = link_shreg[HALF_BITS-1:0];

  // ------------------------------------------------------------------
  // half selection counter
  // ------------------------------------------------------------------
  // a third pulse keeps the upper half rather than wrapping round
  always_comb begin
    next_half = half;
    if (blank_rise) begin
      next_half = HALF_NONE;
    end else if (count_pulse) begin
      case (half)
        HALF_NONE: next_half = HALF_LOW;
        HALF_LOW:  next_half = HALF_HIGH;
        HALF_HIGH: next_half = HALF_HIGH;
        default:   next_half = HALF_NONE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      half       <= HALF_NONE;
      latch_prev <= pin.latch_strobe;
      blank_prev <= pin.blank;
    end else begin
      half       <= next_half;
      latch_prev <= pin.latch_strobe;
      blank_prev <= pin.blank;
    end
  end

  // ------------------------------------------------------------------
  // data latches
  // ------------------------------------------------------------------
  // the shift clock rests while the latch strobe is handled, so the
  // shift register word is stable when sampled here
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_pwm_level_data <= '0;
    end else if (load_full) begin
      o_pwm_level_data <= link_shreg;
    end else if (load_half && half == HALF_LOW) begin
      o_pwm_level_data[HALF_BITS-1:0] <= half_word;
    end else if (load_half && half == HALF_HIGH) begin
      o_pwm_level_data[GS_BITS-1:HALF_BITS] <= half_word;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_current_trim_data <= '0;
    end else if (load_trim) begin
      o_current_trim_data <= link_shreg[DC_BITS-1:0];
    end
  end

  // ------------------------------------------------------------------
  // status capture and link steering
  // ------------------------------------------------------------------
  // status word is frozen in the same cycle the toggle moves, so the link side
  // always sees a settled word behind the toggle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      status_hold <= '0;
      load_tgl    <= 1'b0;
    end else if (arm_status) begin
      status_hold <= flags;
      load_tgl    <= ~load_tgl;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl <= '0;
    end else begin
      ctrl <= '{dc_mode : pin.mode,
                ext     : ext_gs,
                half_hi : next_half == HALF_HIGH};
    end
  end

  // ------------------------------------------------------------------
  // output control
  // ------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_sinks_off      <= 1'b1;
      o_count_clear    <= 1'b1;
      o_lower_half_sel <= 1'b0;
      o_upper_half_sel <= 1'b0;
    end else begin
      o_sinks_off      <= pin.blank;
      o_count_clear    <= pin.blank;
      o_lower_half_sel <= next_half == HALF_LOW;
      o_upper_half_sel <= next_half == HALF_HIGH;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_full_load;
    @(posedge i_clock) disable iff (i_sys_rst)
      load_full |=> o_pwm_level_data == $past(link_shreg);
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("grayscale latch did not take shift register");

  property p_trim_load;
    @(posedge i_clock) disable iff (i_sys_rst)
      load_trim |=> o_current_trim_data == $past(link_shreg[DC_BITS-1:0])
                    && $stable(o_pwm_level_data);
  endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("trim latch load wrong or grayscale disturbed");

  property p_first_pulse;
    @(posedge i_clock) disable iff (i_sys_rst)
      count_pulse && half == HALF_NONE && !blank_rise
        |=> half == HALF_LOW ##1 o_lower_half_sel;
  endproperty
  a_first_pulse: assert property (p_first_pulse)
    else $error("one blanked latch pulse did not select lower half");

  property p_second_pulse;
    @(posedge i_clock) disable iff (i_sys_rst)
      count_pulse && half == HALF_LOW |=> half == HALF_HIGH && o_upper_half_sel;
  endproperty
  a_second_pulse: assert property (p_second_pulse)
    else $error("two blanked latch pulses did not select upper half");

  property p_count_restart;
    @(posedge i_clock) disable iff (i_sys_rst)
      blank_rise |=> half == HALF_NONE && !o_upper_half_sel && !o_lower_half_sel;
  endproperty
  a_count_restart: assert property (p_count_restart)
    else $error("pulse count not restarted by blank rise");

  property p_upper_half_load;
    @(posedge i_clock) disable iff (i_sys_rst)
      load_half && half == HALF_HIGH
        |=> o_pwm_level_data[GS_BITS-1:HALF_BITS] == $past(half_word)
            && $stable(o_pwm_level_data[HALF_BITS-1:0]);
  endproperty
  a_upper_half_load: assert property (p_upper_half_load)
    else $error("upper half load wrong or lower half disturbed");

  property p_blank_counted_only;
    @(posedge i_clock) disable iff (i_sys_rst)
      count_pulse |=> $stable(o_pwm_level_data);
  endproperty
  a_blank_counted_only: assert property (p_blank_counted_only)
    else $error("blanked extended latch pulse changed grayscale data");

  property p_status_arm;
    @(posedge i_clock) disable iff (i_sys_rst)
      arm_status |=> load_tgl != $past(load_tgl) && status_hold == $past(flags);
  endproperty
  a_status_arm: assert property (p_status_arm)
    else $error("latch fall did not arm status load");

  property p_ext_select;
    @(posedge i_clock) disable iff (i_sys_rst)
      !pin.ext_iface_select_n && !pin.mode |=> ctrl.ext;
  endproperty
  a_ext_select: assert property (p_ext_select)
    else $error("extended interface not enabled by low select");

  property p_sinks_off;
    @(posedge i_clock) disable iff (i_sys_rst)
      $rose(pin.blank) |=> o_sinks_off && o_count_clear;
  endproperty
  a_sinks_off: assert property (p_sinks_off)
    else $error("outputs not turned off after blank rose");

endmodule : led_serial_input

`default_nettype wire

// File: verification/led_host_model.sv
// host side model: frames serial data onto the link clock
`default_nettype none

module led_host_model
  import led_serial_pkg::*;
(
  // frame request from the bench
  input  wire logic               i_start,
  input  wire logic [GS_BITS+1:0] i_bits,
  input  wire logic [7:0]         i_count,
  output logic                    o_busy,
  // link pins
  output logic                    o_serial_clk,
  output logic                    o_serial_in,
  input  wire logic               i_serial_out,
  // chain output seen before and just after each rising edge
  output logic      [GS_BITS+1:0] o_pre,
  output logic      [GS_BITS+1:0] o_post
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock rests between frames; 8 MHz shift rate
  // pwm count clock lies outside this block; no link timing uses it
  initial begin
    o_serial_clk = 1'b0;
    o_serial_in = 1'b0;
    o_busy = 1'b0;
    o_pre = '0;
    o_post = '0;
    forever begin
      @(posedge i_start);
      o_busy = 1'b1;
      for (int k = 0; k < int'(i_count); k++) begin
        o_serial_in = i_bits[int'(i_count) - 1 - k];
        #62.5 o_pre[k] = i_serial_out;
        o_serial_clk = 1'b1;
        #10 o_post[k] = i_serial_out;
        #52.5 o_serial_clk = 1'b0;
      end
      // hold time over: the old level is not kept
      #62.5 o_serial_in = ~o_serial_in;
      o_busy = 1'b0;
    end
  end
endmodule : led_host_model

`default_nettype wire

// File: verification/tb_led_serial_input.sv
// self-checking bench of the led serial input block
`default_nettype none

module tb_led_serial_input
  import led_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FW = GS_BITS + 2;
  localparam int NW = GS_BITS + DC_BITS;

  logic              clock, sys_rst, sclk, serial_in, serial_out, start, busy;
  logic              latch, blank, mode, ext_n, otemp, loff, cclr, lsel, usel;
  logic [FW-1:0]     bits, pre, post;
  logic [7:0]        count;
  logic [15:0]       oled;
  logic [GS_BITS-1:0] pwm, exp_pwm, d1, d2;
  logic [DC_BITS-1:0] trim, exp_trim;
  logic [NW-1:0]     last;
  logic [16:0]       stat;
  logic [NW-1:0]     notes[$];
  int                seed = 92;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cycles = 0;

  led_serial_input dut (.i_clock(clock), .i_sys_rst(sys_rst), .i_serial_clk(sclk),
    .i_serial_in(serial_in), .o_serial_out(serial_out), .i_latch_strobe(latch), .i_blank(blank),
    .i_mode(mode), .i_ext_iface_select_n(ext_n), .i_open_led_flags(oled),
    .i_overtemp_flag(otemp), .o_pwm_level_data(pwm), .o_current_trim_data(trim),
    .o_sinks_off(loff), .o_count_clear(cclr), .o_lower_half_sel(lsel),
    .o_upper_half_sel(usel));

  led_host_model host (.i_start(start), .i_bits(bits), .i_count(count), .o_busy(busy),
    .o_serial_clk(sclk), .o_serial_in(serial_in), .i_serial_out(serial_out), .o_pre(pre),
    .o_post(post));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [NW-1:0] got, input logic [NW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [GS_BITS-1:0] rnd;
    logic [GS_BITS-1:0] r;
    for (int i = 0; i < 6; i++) begin
      r[i*32 +: 32] = $random(seed);
    end
    return r;
  endfunction : rnd

  // two leading filler bits cover the steering sync after a mode change
  task automatic send(input logic [GS_BITS-1:0] d, input int n);
    bits <= (FW'(d) & ((FW'(1) << n) - FW'(1))) | (FW'(2'b10) << n);
    count <= 8'(n + 2);
    start <= 1'b1;
    for (int i = 0; i < 100 && !busy; i++) @(posedge clock);
    start <= 1'b0;
    for (int i = 0; i < 2000 && busy; i++) @(posedge clock);
    @(posedge clock);
  endtask : send

  task automatic pulse_latch;
    @(posedge clock) latch <= 1'b1;
    repeat (4) @(posedge clock);
    latch <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pulse_latch

  // note goes in first: the latched word changes inside the pulse
  task automatic latch_note;
    notes.push_back({exp_pwm, exp_trim});
    pulse_latch();
  endtask : latch_note

  // data outputs: every change is matched with the oldest note
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      give_verdict();
    end
    if (sys_rst) begin
      last <= '0;
    end else if ({pwm, trim} !== last) begin
      last <= {pwm, trim};
      if (notes.size() == 0) begin
        check({pwm, trim}, last);
      end else begin
        check({pwm, trim}, notes.pop_front());
      end
    end
  end

  initial begin
    {sys_rst, blank, ext_n} = 3'b111;
    {latch, mode, start, otemp} = 4'h0;
    bits = '0;
    count = 8'h00;
    oled = 16'h0000;
    {exp_pwm, exp_trim} = '0;
    // link reset needs serial edges while reset is high
    repeat (4) @(posedge clock);
    send(rnd(), 4);
    check(NW'({loff, cclr, lsel, usel}), NW'(4'hc));
    check({pwm, trim}, NW'(0));
    sys_rst <= 1'b0;
    oled <= 16'($random(seed));
    otemp <= 1'b1;
    repeat (4) @(posedge clock);
    blank <= 1'b0;
    repeat (6) @(posedge clock);
    check({loff, cclr}, 2'b00);
    blank <= 1'b1;
    repeat (6) @(posedge clock);
    check({loff, cclr}, 2'b11);
    // trim path and chain pass-through, latch kept low across mode switch
    mode <= 1'b1;
    d1 = rnd();
    send(d1, DC_BITS);
    exp_trim = d1[95:0];
    latch_note();
    d2 = rnd();
    send(d2, DC_BITS);
    check(pre[95:0], {<<{d1[95:0]}});
    check(post[94:0], pre[95:1]);
    exp_trim = d2[95:0];
    latch_note();
    // grayscale path, then status on the following frame
    mode <= 1'b0;
    d1 = rnd();
    send(d1, GS_BITS);
    exp_pwm = d1;
    latch_note();
    d2 = rnd();
    send(d2, GS_BITS);
    stat = {<<{otemp, oled}};
    check(pre[19:3], stat);
    exp_pwm = d2;
    latch_note();
    // extended: one blanked pulse picks the lower half
    ext_n <= 1'b0;
    pulse_latch();
    check({lsel, usel}, 2'b10);
    d1 = rnd();
    send(d1, HALF_BITS);
    blank <= 1'b0;
    exp_pwm[95:0] = d1[95:0];
    latch_note();
    // blank rise restarts the count; two pulses pick the upper half
    blank <= 1'b1;
    repeat (2) pulse_latch();
    check({lsel, usel}, 2'b01);
    d2 = rnd();
    send(d2, HALF_BITS);
    check(post[97:0], pre[97:0]);
    blank <= 1'b0;
    exp_pwm[191:96] = d2[95:0];
    latch_note();
    // trim mode with the extended select still low
    mode <= 1'b1;
    d1 = rnd();
    send(d1, DC_BITS);
    exp_trim = d1[95:0];
    latch_note();
    repeat (10) @(posedge clock);
    check(notes.size(), 0);
    give_verdict();
  end
endmodule : tb_led_serial_input

`default_nettype wire
